//--- bus_pin_sync.sv
/*
  Two-flop synchronisers for the clock and data lines, with edge,
  START and STOP detection on the synchronised levels.
  Assumes both lines idle high (pulled up) outside transfers.
*/
`timescale 1ns/100ps
module bus_pin_sync
  import smb_engine_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // Bus lines
  input  wire logic    scl_in,
  input  wire logic    sda_in,
  // Events
  output pin_ev_t      ev
);

  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [2:0] scl_d;
  logic [2:0] sda_d;

  always_comb
  begin
    scl_d = {scl_q[1:0], scl_in};
    sda_d = {sda_q[1:0], sda_in};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end
    else
    begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  always_comb
  begin
    ev.scl      = scl_q[1];
    ev.sda      = sda_q[1];
    ev.scl_rise = scl_q[1] & ~scl_q[2];
    ev.scl_fall = ~scl_q[1] & scl_q[2];
    ev.start    = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    ev.stop     = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  end

endmodule : bus_pin_sync

//--- scl_tick_gen.sv
/*
  Divider giving a one-cycle enable at each half period of the
  generated serial clock. Restarts whenever run is low.
*/
`timescale 1ns/100ps
module scl_tick_gen
  import smb_engine_pkg::*;
#(
  parameter int HALF_CYCLES = SCL_HALF_CYCLES
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  output logic      tick
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  always_comb
  begin
    tick  = run && (cnt_q == 16'(HALF_CYCLES - 1));
    cnt_d = (!run || tick) ? 16'h0000 : cnt_q + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

endmodule : scl_tick_gen

//--- smb_bus_partner.sv
/*
  Behavioural bus slave: acks its address, stores written bytes
  and sends a fixed byte on reads. Assumes pulled-up lines.
*/
`timescale 1ns/100ps
module smb_bus_partner
#(
  parameter logic [6:0] ADDR    = 7'h50,
  parameter logic [7:0] RD_BYTE = 8'hc4
)
(
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Drive and capture
  output logic            sda_oe,
  output logic      [7:0] last_byte
);
  logic [7:0] sh;
  logic       rd;
  int         i;

  initial sda_oe = 1'b0;

  // STOP ends the frame and frees the line
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      disable frame_blk;
      sda_oe = 1'b0;
    end

  always @(negedge sda)
    if (scl === 1'b1)
    begin : frame_blk
      for (i = 0; i < 8; i++)
      begin
        @(posedge scl);
        sh = {sh[6:0], sda};
      end
      if (sh[7:1] != ADDR) disable frame_blk;
      rd = sh[0];
      @(negedge scl);
      #100 sda_oe = 1'b1;
      @(negedge scl);
      #100 sda_oe = 1'b0;
      forever
      begin
        if (rd)
        begin
          for (i = 7; i >= 0; i--)
          begin
            sda_oe = ~RD_BYTE[i];
            @(negedge scl);
            #100;
          end
          sda_oe = 1'b0;
          @(posedge scl);
          if (sda) disable frame_blk;
          @(negedge scl);
          #100;
        end
        else
        begin
          for (i = 0; i < 8; i++)
          begin
            @(posedge scl);
            sh = {sh[6:0], sda};
          end
          last_byte = sh;
          @(negedge scl);
          #100 sda_oe = 1'b1;
          @(negedge scl);
          #100 sda_oe = 1'b0;
        end
      end
    end
endmodule : smb_bus_partner

//--- smb_engine_assertions.sv
/*
  Port checker for the serial bus byte engine.
  Assumes it is bound onto smbus_transfer_mode_engine.
*/
`timescale 1ns/100ps
module smb_engine_assertions
  import smb_engine_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Event and bus
  input wire logic       byte_event,
  input wire logic       scl_oe,
  input wire logic       sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_quiet_a: assert property ($past(!rst_n) |->
    !scl_oe && !sda_oe && !byte_event && sfr_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  scl_hold_a: assert property (byte_event && $past(byte_event)
    |-> scl_oe) else $error("clock line free during event");
  event_hold_a: assert property (byte_event && !sfr_wr
    && !$past(sfr_wr) |=> byte_event) else $error("event dropped");
  event_low_a: assert property ($rose(byte_event) && $past(rst_n)
    |-> scl_oe) else $error("event raised with clock free");
  clear_cause_a: assert property ($fell(byte_event) && $past(rst_n)
    |-> $past(sfr_wr) || $past(sfr_wr, 2))
    else $error("event cleared without a write");
  release_a: assert property ($fell(scl_oe) && $past(rst_n)
    |-> !byte_event) else $error("clock freed during event");
  data_keep_a: assert property (byte_event && $past(byte_event)
    && $past(byte_event, 2) && !$past(sfr_wr) && !$past(sfr_wr, 2)
    && $past(sfr_addr) == DATA_OFS && $past(sfr_addr, 2) == DATA_OFS
    |-> $stable(sfr_rdata)) else $error("data moved during event");
  data_write_a: assert property (byte_event && sfr_wr
    && sfr_addr == DATA_OFS ##1 sfr_addr == DATA_OFS && !sfr_wr
    |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("data write lost");

  cover property ($rose(byte_event));
  cover property ($fell(scl_oe));
  cover property (byte_event && sfr_wr && sfr_addr == DATA_OFS);
endmodule : smb_engine_assertions

bind smbus_transfer_mode_engine smb_engine_assertions u_chk (
  .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .byte_event(byte_event), .scl_oe(scl_oe), .sda_oe(sda_oe));

//--- smb_engine_pkg.sv
/*
  Shared constants and types of the serial bus byte engine.
  Assumes a 20 MHz system clock and the documented register port.
*/
package smb_engine_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'hc0;
  localparam logic [7:0] DATA_OFS   = 8'hc2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Frame positions
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int SCL_HALF_NS     = 5000;
  localparam int SCL_HALF_CYCLES =
    (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic master;
    logic txmode;
    logic start_request_bit;
    logic stop_request_bit;
    logic ack_request_flag;
    logic arb_lost;
    logic ack;
    logic byte_event;
  } ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } pin_ev_t;

  typedef enum logic [2:0] {
    M_IDLE   = 3'b000,
    M_START  = 3'b001,
    M_RUN    = 3'b011,
    M_STOP_A = 3'b010,
    M_STOP_B = 3'b110,
    M_RS_A   = 3'b111,
    M_RS_B   = 3'b101
  } mst_state_t;

endpackage : smb_engine_pkg

//--- smbus_transfer_mode_engine.sv
/*
  Byte transfer engine: data register, control flags and the four
  transfer modes on an open-drain clock and data line pair.
  Assumes external pull-ups and a single-cycle register port.
*/
`timescale 1ns/100ps

// What this block does
// R1 - Software touches the data byte only while the byte event flag is set.
// R2 - Data byte stays unchanged while the byte event flag is set.
// R3 - Bytes shift out MSB first; first received bit lands in MSB.
// R4 - Bus value is shifted in while sending; register holds last bus byte.
// R5 - Lost arbitration turns master transmitter into receiver, byte intact.
// R6 - Master from generated START until STOP or lost arbitration.
// R7 - Byte event before ACK as receiver, after ACK as transmitter.
// R8 - Master transmitter drives clock, makes START, sends address and data.
// R9 - No data write after transmit event means receive; stop bit ends it.
// R10 - Master receiver sends read address then clocks bytes in.
// R11 - Each received byte sets ack request; software picks ACK or NACK.
// R12 - Master receiver software NACKs last byte then requests STOP.
// R13 - Data write as active master receiver switches to transmitter.
// R14 - Enabled slave enters receiver on write address, flags and interrupts.
// R15 - NACKed address mutes slave until next START; ACK receives data.
// R16 - Slave receiver leaves on STOP; data write switches to transmit.
// R17 - Read address received, ACKed and loaded, then bytes are sent.
// R18 - Slave transmitter software loads after ACK, never before clear on NACK.
// R19 - No write after slave transmit event means receive; STOP ends it.
// R20 - Clock line held low while the byte event flag is set; the slave STOP event clears active_q and leaves it free.
// R21 - Stop request bit clears itself once the STOP is made.
// R22 - ACK bit and new data taken when the event flag clears.
module smbus_transfer_mode_engine
  import smb_engine_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR    = 7'h2a,
  parameter int         HALF_CYCLES = SCL_HALF_CYCLES
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Configuration
  input  wire logic       bus_enable,
  input  wire logic       slave_event_inhibit,
  // Event
  output logic            byte_event,
  // Bus lines
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);

  // ----------------------------------------------------------------
  // Pin sampling and clock divider
  // ----------------------------------------------------------------
  pin_ev_t ev;
  logic    tick;

  mst_state_t mst_q;
  mst_state_t mst_d;

  bus_pin_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .ev     (ev)
  );

  scl_tick_gen #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (mst_q != M_IDLE),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  ctrl_t       ctl_q;
  ctrl_t       ctl_d;
  logic [7:0]  serial_data_byte_reg_q;
  logic [7:0]  dat_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic        active_q;
  logic        active_d;
  logic        addr_ph_q;
  logic        addr_ph_d;
  logic        sel_q;
  logic        sel_d;
  logic        supp_q;
  logic        supp_d;
  logic        wrote_q;
  logic        wrote_d;
  logic        busy_q;
  logic        busy_d;
  logic        sda_low_q;
  logic        sda_low_d;
  logic        scl_low_q;
  logic        scl_low_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        si_clear;
  logic        go;
  logic        match;

  always_comb
  begin
    ctl_d     = ctl_q;
    dat_d     = serial_data_byte_reg_q;
    bit_d     = bit_q;
    active_d  = active_q;
    addr_ph_d = addr_ph_q;
    sel_d     = sel_q;
    supp_d    = supp_q;
    wrote_d   = wrote_q;
    busy_d    = busy_q;
    sda_low_d = sda_low_q;
    scl_low_d = scl_low_q;
    mst_d     = mst_q;
    go        = 1'b0;
    match     = (serial_data_byte_reg_q[7:1] == OWN_ADDR) &&
                !slave_event_inhibit && !supp_q;

    // Software writes; data only while the event flag stands
    if (sfr_wr && sfr_addr == CTRL_OFS)
    begin
      ctl_d.start_request_bit = sfr_wdata[5];
      ctl_d.stop_request_bit  = sfr_wdata[4];
      ctl_d.ack               = sfr_wdata[1];
      ctl_d.byte_event        = ctl_q.byte_event & sfr_wdata[0];
    end
    if (sfr_wr && sfr_addr == DATA_OFS && ctl_q.byte_event) // see R1
    begin
      dat_d   = sfr_wdata;
      wrote_d = 1'b1;
    end
    si_clear = ctl_q.byte_event && !ctl_d.byte_event;
    if (si_clear)
      ctl_d.arb_lost = 1'b0;

    // Flag release: receiver drives chosen ACK, transmitter moves on
    if (si_clear && active_q && bit_q == BIT_ACK)
    begin
      if (ctl_q.txmode)
        go = 1'b1;                                  // see R22
      else
        sda_low_d = ctl_d.ack;                      // see R11 see R22
    end

    // Bit sampling on the rising clock edge
    if (ev.scl_rise && active_q && !ctl_q.byte_event)
    begin
      if (bit_q < BIT_ACK)
      begin
        dat_d = {serial_data_byte_reg_q[6:0], ev.sda}; // see R3 see R4
        if (ctl_q.txmode && !sda_low_q && !ev.sda)
        begin
          ctl_d.arb_lost = 1'b1;                    // see R5
          ctl_d.txmode   = 1'b0;
          if (ctl_q.master)
          begin
            ctl_d.master = 1'b0;                    // see R6
            mst_d        = M_IDLE;
            scl_low_d    = 1'b0;
          end
        end
      end
      else if (ctl_q.txmode)
        ctl_d.ack = ~ev.sda;
    end

    // Bit advance on the falling clock edge
    if (ev.scl_fall && active_q && !ctl_q.byte_event)
    begin
      if (bit_q < BIT_LAST)
      begin
        bit_d     = bit_q + 4'h1;
        sda_low_d = ctl_q.txmode & ~serial_data_byte_reg_q[7]; // see R3
      end
      else if (bit_q == BIT_LAST)
      begin
        bit_d     = BIT_ACK;
        sda_low_d = 1'b0;
        if (addr_ph_q)
        begin
          if (match)
          begin
            sel_d                   = 1'b1;         // see R14 see R17
            ctl_d.byte_event        = 1'b1;
            ctl_d.ack_request_flag  = 1'b1;
            ctl_d.start_request_bit = 1'b1;
            ctl_d.txmode            = 1'b0;
          end
          else
          begin
            active_d  = 1'b0;
            addr_ph_d = 1'b0;
          end
        end
        else if (!ctl_q.txmode)
        begin
          ctl_d.byte_event       = 1'b1;            // see R7 see R11
          ctl_d.ack_request_flag = 1'b1;
        end
      end
      else if (ctl_q.txmode)
      begin
        ctl_d.byte_event = 1'b1;                    // see R7
        sda_low_d        = 1'b0;
      end
      else
        go = 1'b1;
    end

    // Start of the next byte, or end of the transfer
    if (go)
    begin
      bit_d                  = 4'h0;
      wrote_d                = 1'b0;
      addr_ph_d              = 1'b0;
      ctl_d.ack_request_flag = 1'b0;
      sda_low_d              = 1'b0;
      if (addr_ph_q && !ctl_q.ack)
      begin
        supp_d   = 1'b1;                            // see R15
        active_d = 1'b0;
        sel_d    = 1'b0;
      end
      else if (ctl_q.master && ctl_d.stop_request_bit)
      begin
        mst_d    = M_STOP_A;                        // see R9
        active_d = 1'b0;
      end
      else if (ctl_q.master && ctl_d.start_request_bit)
      begin
        mst_d    = M_RS_A;
        active_d = 1'b0;
      end
      else
      begin
        ctl_d.txmode = wrote_q;             // see R9 see R13 see R16 see R19
        sda_low_d    = wrote_q & ~serial_data_byte_reg_q[7];
      end
    end

    // Conditions seen on the bus
    if (ev.start)
      busy_d = 1'b1;
    if (ev.stop)
      busy_d = 1'b0;
    if (ev.start && mst_q == M_IDLE && !ctl_q.master && bus_enable)
    begin
      supp_d       = 1'b0;                          // see R15
      active_d     = 1'b1;
      addr_ph_d    = 1'b1;
      sel_d        = 1'b0;
      bit_d        = 4'h0;
      ctl_d.txmode = 1'b0;
      sda_low_d    = 1'b0;
    end
    if (ev.stop && mst_q == M_IDLE && !ctl_q.master)
    begin
      if (sel_q)
      begin
        ctl_d.stop_request_bit = 1'b1;              // see R16 see R19
        ctl_d.byte_event       = 1'b1;
      end
      sel_d        = 1'b0;
      active_d     = 1'b0;
      ctl_d.txmode = 1'b0;
      sda_low_d    = 1'b0;
    end

    // Master condition and clock generation
    unique case (mst_q)
      M_IDLE:
        if (ctl_q.start_request_bit && !ctl_q.master && !busy_q &&
            !active_q && bus_enable)
        begin
          sda_low_d = 1'b1;
          mst_d     = M_START;
        end
      M_START:
        if (tick)
        begin
          scl_low_d        = 1'b1;
          ctl_d.master     = 1'b1;                  // see R6 see R8
          ctl_d.txmode     = 1'b1;
          ctl_d.byte_event = 1'b1;
          active_d         = 1'b1;
          addr_ph_d        = 1'b0;
          sel_d            = 1'b0;
          bit_d            = BIT_ACK;
          mst_d            = M_RUN;
        end
      M_RUN:
        if (tick && active_q && !ctl_q.byte_event)
        begin
          if (scl_low_q)
            scl_low_d = 1'b0;                       // see R8 see R10
          else if (ev.scl)
            scl_low_d = 1'b1;
        end
      M_STOP_A:
      begin
        sda_low_d = 1'b1;
        if (tick && sda_low_q)
        begin
          scl_low_d = 1'b0;
          mst_d     = M_STOP_B;
        end
      end
      M_STOP_B:
        if (tick && ev.scl)
        begin
          sda_low_d              = 1'b0;
          ctl_d.stop_request_bit = 1'b0;            // see R21
          ctl_d.master           = 1'b0;            // see R6
          ctl_d.txmode           = 1'b0;
          mst_d                  = M_IDLE;
        end
      M_RS_A:
      begin
        sda_low_d = 1'b0;
        if (tick && !sda_low_q)
        begin
          scl_low_d = 1'b0;
          mst_d     = M_RS_B;
        end
      end
      M_RS_B:
        if (tick && ev.scl)
        begin
          sda_low_d = 1'b1;
          mst_d     = M_START;
        end
      default:
      begin
        mst_d     = M_IDLE;
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
      end
    endcase

    // Registered read data
    rdata_d = 8'h00;
    if (sfr_addr == CTRL_OFS)
      rdata_d = ctl_d;
    else if (sfr_addr == DATA_OFS)
      rdata_d = serial_data_byte_reg_q;             // see R2
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl_q                  <= ctrl_t'(CTRL_RESET);
      serial_data_byte_reg_q <= DATA_RESET;
      bit_q                  <= 4'h0;
      active_q               <= 1'b0;
      addr_ph_q              <= 1'b0;
      sel_q                  <= 1'b0;
      supp_q                 <= 1'b0;
      wrote_q                <= 1'b0;
      busy_q                 <= 1'b0;
      sda_low_q              <= 1'b0;
      scl_low_q              <= 1'b0;
      mst_q                  <= M_IDLE;
      rdata_q                <= 8'h00;
    end
    else
    begin
      ctl_q                  <= ctl_d;
      serial_data_byte_reg_q <= dat_d;
      bit_q                  <= bit_d;
      active_q               <= active_d;
      addr_ph_q              <= addr_ph_d;
      sel_q                  <= sel_d;
      supp_q                 <= supp_d;
      wrote_q                <= wrote_d;
      busy_q                 <= busy_d;
      sda_low_q              <= sda_low_d;
      scl_low_q              <= scl_low_d;
      mst_q                  <= mst_d;
      rdata_q                <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    sfr_rdata  = rdata_q;
    byte_event = ctl_q.byte_event;
    scl_out    = 1'b0;
    sda_out    = 1'b0;
    scl_oe     = scl_low_q |
                 (ctl_q.byte_event & active_q & ~ctl_q.master); // see R20
    sda_oe     = sda_low_q;
  end

endmodule : smbus_transfer_mode_engine

//--- smbus_transfer_mode_engine_bench.sv
/*
  Register-level bench of the serial bus byte engine as master.
  Assumes the bus partner model and the bound checker.
*/
`timescale 1ns/100ps
module smbus_transfer_mode_engine_bench
  import smb_engine_pkg::*;
;
  logic       clk, rst_n, sfr_wr, scl_oe, sda_oe, ev, p_oe;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv, p_byte;
  logic       scl_drv, sda_drv;
  wire        scl, sda;
  int         error_cnt, n_tests, cyc;

  assign scl = ~scl_oe;
  assign sda = ~(sda_oe | p_oe);

  smbus_transfer_mode_engine #(.HALF_CYCLES(4)) u_dut (
    .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bus_enable(1'b1),
    .slave_event_inhibit(1'b0), .byte_event(ev), .scl_in(scl),
    .scl_out(scl_drv), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_drv), .sda_oe(sda_oe));

  smb_bus_partner u_part (.scl(scl), .sda(sda), .sda_oe(p_oe),
    .last_byte(p_byte));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(string nm, logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : check

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    #5 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #5 sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(posedge clk);
    #5 sfr_addr = a;
    @(posedge clk);
    #5 rv = sfr_rdata;
  endtask : rd

  task automatic wait_ev();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    #5;
    while (ev !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #5 n++;
    end
    if (n >= 3000)
      error_cnt++;
  endtask : wait_ev

  task automatic wait_idle();
    int n;
    n = 0;
    rv = 8'hff;
    while (rv[7] !== 1'b0 && n < 300)
    begin
      rd(CTRL_OFS);
      n++;
    end
  endtask : wait_idle

  task automatic open_xfer(logic [7:0] adr);
    wr(CTRL_OFS, 8'h20);
    wait_ev();
    rd(CTRL_OFS);
    check("start", rv & 8'hfd, 8'he1);
    wr(DATA_OFS, adr);
    rd(DATA_OFS);
    check("addr", rv, adr);
    wr(CTRL_OFS, 8'h00);
    wait_ev();
    check("scl", {7'h00, scl}, 8'h00);
    check("drive level", {6'h00, scl_drv, sda_drv}, 8'h00);
    rd(CTRL_OFS);
    check("addr ack", rv, 8'hc3);
  endtask : open_xfer

  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    #5 rst_n = 1'b1;
    rd(CTRL_OFS);
    check("ctrl reset", rv, CTRL_RESET);
    rd(8'h55);
    check("unmapped", rv, 8'h00);
    wr(DATA_OFS, 8'h3c);
    rd(DATA_OFS);
    check("dropped write", rv, DATA_RESET);
    // Master transmit, then STOP
    open_xfer(8'ha0);
    wr(DATA_OFS, 8'h96);
    wr(CTRL_OFS, 8'h00);
    wait_ev();
    check("tx byte", p_byte, 8'h96);
    rd(CTRL_OFS);
    check("tx ack", rv, 8'hc3);
    rd(DATA_OFS);
    check("bus byte", rv, 8'h96);
    wr(CTRL_OFS, 8'h10);
    wait_idle();
    check("stop", rv & 8'hf1, 8'h00);
    // Master receive, ACK one byte, NACK the last
    open_xfer(8'ha1);
    wr(CTRL_OFS, 8'h00);
    wait_ev();
    rd(CTRL_OFS);
    check("rx mode", rv & 8'hfd, 8'h89);
    rd(DATA_OFS);
    check("rx byte", rv, 8'hc4);
    wr(CTRL_OFS, 8'h02);
    wait_ev();
    rd(CTRL_OFS);
    check("rx again", rv & 8'hfd, 8'h89);
    rd(DATA_OFS);
    check("rx byte 2", rv, 8'hc4);
    wr(CTRL_OFS, 8'h10);
    wait_idle();
    check("rx stop", rv & 8'hf1, 8'h00);
    stop_test();
  end
endmodule : smbus_transfer_mode_engine_bench
